// file: common/pin_pkg.sv
// Purpose: Shared constants and types for the posted interrupt notify block
// Assumes: Descriptor is 512 bits, accessed as one atomic read-modify-write
// Notes:   Field positions follow the descriptor layout
package pin_pkg;
    localparam int DESC_W        = 512;
    localparam int REQ_LO        = 0;
    localparam int REQ_HI        = 255;
    localparam int OUTST_BIT     = 256;
    localparam int SUPP_BIT      = 257;
    localparam int VEC_LO        = 272;
    localparam int VEC_HI        = 279;
    localparam int DST_LO        = 288;
    localparam int DST_HI        = 319;
    localparam int DST8_LO       = 296;
    localparam int DST8_HI       = 303;
    localparam int VEC_W         = 8;
    localparam int DST_W         = 32;
    localparam int ALIGN_W       = 6;    // Descriptor alignment, low address bits dropped

    typedef struct packed {
        logic             posting_mode_flag;
        logic             urgent_flag;
        logic [VEC_W-1:0] vector;
    } pin_remap_t;

    typedef struct packed {
        logic [DST_W-1:0] notify_destination;
        logic [VEC_W-1:0] notify_vector;
        logic             edge_trigger;
        logic             level_asserted;
    } pin_notify_t;

    typedef enum logic {
        PIN_DST_8 = 1'b0,
        PIN_DST_32 = 1'b1
    } pin_dst_mode_t;
endpackage : pin_pkg

// file: logic/pin_decide.sv
// Purpose: Combinational posting decision on one descriptor image
// Assumes: Caller registers the results
// Notes:   Pure function of the read descriptor, request and destination mode
`timescale 1ns/1ps
module pin_decide (
    input  wire logic [pin_pkg::DESC_W-1:0] desc_in,
    input  wire pin_pkg::pin_remap_t        req,
    input  wire pin_pkg::pin_dst_mode_t     dst_mode,
    output logic [pin_pkg::DESC_W-1:0]      desc_out,
    output logic                            send,
    output pin_pkg::pin_notify_t            note
);
    import pin_pkg::*;
    logic non_urgent;
    logic suppressed;

    assign non_urgent = req.posting_mode_flag && !req.urgent_flag;
    assign suppressed = non_urgent && desc_in[SUPP_BIT];

    always_comb begin
        desc_out = desc_in;
        desc_out[REQ_LO + int'(req.vector)] = 1'b1;
        send = 1'b0;
        if (!suppressed && !desc_in[OUTST_BIT]) begin
            desc_out[OUTST_BIT] = 1'b1;
            send = 1'b1;
        end
        note.notify_vector = desc_in[VEC_HI:VEC_LO];
        note.edge_trigger = 1'b1;
        note.level_asserted = 1'b1;
        if (dst_mode == PIN_DST_32) begin
            note.notify_destination = desc_in[DST_HI:DST_LO];
        end else begin
            note.notify_destination = DST_W'(desc_in[DST8_HI:DST8_LO]);
        end
    end
endmodule : pin_decide

// file: logic/pin_notify.sv
// Purpose: Posts remapped interrupts into a descriptor and issues notifications
// Assumes: Memory port grants an atomic locked read then write of one descriptor
// Notes:   One request in flight; notification only after write is acknowledged
//
// Overview of operation
// - 8-bit mode destination from bits 303:296
// - 32-bit mode destination from bits 319:288
// - Notification vector from bits 279:272
// - Notify is physical, edge, level asserted
// - Non-urgent means posting set, urgent clear
// - Suppress on non-urgent: post bit, no notify, outstanding unchanged
// - Outstanding clear: set it and notify
// - Outstanding set: post bit, no notify
// - Outstanding one means notify pending at processor
// - Low 256 bits are per-vector request bitmap
// - Posted once vector bit is set
`timescale 1ns/1ps
module pin_notify #(
    parameter int ADDR_W = 64
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire pin_pkg::pin_dst_mode_t      dst_mode,
    input  wire logic                        req_valid,
    input  wire pin_pkg::pin_remap_t         req,
    input  wire logic [ADDR_W-1:0]           req_addr,
    output logic                             req_ready,
    output logic                             mem_rd,
    output logic                             mem_wr,
    output logic                             mem_lock,
    output logic [ADDR_W-1:0]                mem_addr,
    output logic [pin_pkg::DESC_W-1:0]       mem_wdata,
    input  wire logic                        mem_rvalid,
    input  wire logic [pin_pkg::DESC_W-1:0]  mem_rdata,
    input  wire logic                        mem_wack,
    output logic                             notify_valid,
    output pin_pkg::pin_notify_t             notify,
    input  wire logic                        notify_ready
);
    import pin_pkg::*;

    // Low address bits are dropped for alignment, so the address must be wider
    if (ADDR_W <= ALIGN_W) begin : g_addr_check
        $error("ADDR_W too small for aligned descriptor");
    end

    typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_NOTE, S_DONE} pin_state_t;
    pin_state_t state_r;
    pin_remap_t req_r;
    logic [DESC_W-1:0] desc_nxt;
    logic send_nxt;
    logic send_r;
    pin_notify_t note_nxt;

    pin_decide u_decide (
        .desc_in  (mem_rdata),
        .req      (req_r),
        .dst_mode (dst_mode),
        .desc_out (desc_nxt),
        .send     (send_nxt),
        .note     (note_nxt)
    );

    // One descriptor in flight; ready returns one cycle after done
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= S_IDLE;
        end else begin
            unique case (state_r)
                S_IDLE:  if (req_valid && req_ready) state_r <= S_READ;
                S_READ:  if (mem_rvalid) state_r <= S_WRITE;
                S_WRITE: if (mem_wack) state_r <= send_r ? S_NOTE : S_DONE;
                S_NOTE:  if (notify_ready) state_r <= S_DONE;
                S_DONE:  state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            req_ready <= 1'b1;
            req_r <= '0;
            mem_addr <= '0;
        end else if (state_r == S_IDLE && req_valid && req_ready) begin
            req_ready <= 1'b0;
            req_r <= req;
            mem_addr <= {req_addr[ADDR_W-1:ALIGN_W], ALIGN_W'(0)};
        end else if (state_r == S_DONE) begin
            req_ready <= 1'b1;
        end
    end

    // Lock held from read through write so processor updates are not lost
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_lock <= 1'b0;
            mem_wdata <= '0;
            send_r <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            if (state_r == S_IDLE && req_valid && req_ready) begin
                mem_rd <= 1'b1;
                mem_lock <= 1'b1;
            end
            if (state_r == S_READ && mem_rvalid) begin
                mem_wr <= 1'b1;
                mem_wdata <= desc_nxt;
                send_r <= send_nxt;
            end
            if (state_r == S_WRITE && mem_wack) begin
                mem_wr <= 1'b0;
                mem_lock <= 1'b0;
            end
        end
    end

    // Captured at read time so a later mode change cannot alter a pending event
    always_ff @(posedge clock) begin
        if (rst) begin
            notify_valid <= 1'b0;
            notify <= '0;
        end else begin
            if (state_r == S_READ && mem_rvalid) notify <= note_nxt;
            if (state_r == S_WRITE && mem_wack && send_r) notify_valid <= 1'b1;
            else if (notify_valid && notify_ready) notify_valid <= 1'b0;
        end
    end

    a_notify_after_ack: assert property (@(posedge clock) disable iff (rst)
        $rose(notify_valid) |-> $past(mem_wack) && $past(state_r) == S_WRITE)
        else $error("notify raised without write ack");
    a_lock_over_write: assert property (@(posedge clock) disable iff (rst)
        mem_wr |-> mem_lock)
        else $error("write outside locked sequence");
    a_bitmap_set: assert property (@(posedge clock) disable iff (rst)
        mem_wr |-> mem_wdata[REQ_LO + int'(req_r.vector)])
        else $error("request bit not set in written descriptor");
    a_suppress_quiet: assert property (@(posedge clock) disable iff (rst)
        (state_r == S_READ && mem_rvalid && req_r.posting_mode_flag && !req_r.urgent_flag
         && mem_rdata[SUPP_BIT]) |=> !send_r && mem_wdata[OUTST_BIT] == $past(mem_rdata[OUTST_BIT]))
        else $error("suppressed request changed flag or sent");
    a_outst_set_quiet: assert property (@(posedge clock) disable iff (rst)
        (state_r == S_READ && mem_rvalid && mem_rdata[OUTST_BIT]) |=> !send_r)
        else $error("notify sent with outstanding already set");
    a_outst_clear_send: assert property (@(posedge clock) disable iff (rst)
        (state_r == S_READ && mem_rvalid && !mem_rdata[OUTST_BIT] && !mem_rdata[SUPP_BIT])
        |=> send_r && mem_wdata[OUTST_BIT])
        else $error("clear flag did not trigger notify");
    a_notify_format: assert property (@(posedge clock) disable iff (rst)
        notify_valid |-> notify.edge_trigger && notify.level_asserted)
        else $error("notify not edge asserted");
    a_dst8_zero: assert property (@(posedge clock) disable iff (rst)
        (notify_valid && dst_mode == PIN_DST_8) |-> notify.notify_destination[DST_W-1:DST8_HI-DST8_LO+1] == '0)
        else $error("8-bit destination upper bits nonzero");
    a_vector_held: assert property (@(posedge clock) disable iff (rst)
        (notify_valid && !notify_ready) |=> notify_valid && $stable(notify))
        else $error("notify dropped or changed before accept");

    // Steps of one locked descriptor update
    sequence s_accept;
        state_r == S_IDLE && req_valid && req_ready;
    endsequence

    sequence s_read_issue;
        mem_rd && mem_lock && !req_ready && state_r == S_READ;
    endsequence

    sequence s_data_back;
        state_r == S_READ && mem_rvalid;
    endsequence

    sequence s_write_issue;
        mem_wr && mem_lock && state_r == S_WRITE
        && mem_wdata[DESC_W-1:SUPP_BIT] == $past(mem_rdata[DESC_W-1:SUPP_BIT]);
    endsequence

    sequence s_write_done;
        state_r == S_WRITE && mem_wack;
    endsequence

    sequence s_released;
        !mem_wr && !mem_lock;
    endsequence

    a_accept_read: assert property (@(posedge clock) disable iff (rst)
        s_accept |=> s_read_issue)
        else $error("accepted request did not start locked read");

    a_read_write: assert property (@(posedge clock) disable iff (rst)
        s_data_back |=> s_write_issue)
        else $error("read data did not lead to locked write");

    a_write_release: assert property (@(posedge clock) disable iff (rst)
        s_write_done |=> s_released)
        else $error("write or lock held after ack");

    a_quiet_no_notify: assert property (@(posedge clock) disable iff (rst)
        (state_r == S_WRITE && mem_wack && !send_r) |=> !notify_valid)
        else $error("notify raised without send decision");

    // Decoded fields must come from the descriptor just read
    a_vector_from_desc: assert property (@(posedge clock) disable iff (rst)
        s_data_back |=> notify.notify_vector == $past(mem_rdata[VEC_HI:VEC_LO]))
        else $error("notify vector not taken from descriptor");

    a_dst32_full: assert property (@(posedge clock) disable iff (rst)
        (state_r == S_READ && mem_rvalid && dst_mode == PIN_DST_32) |=> notify.notify_destination == $past(mem_rdata[DST_HI:DST_LO]))
        else $error("32-bit destination not taken from descriptor");

    a_busy_not_ready: assert property (@(posedge clock) disable iff (rst)
        (state_r != S_IDLE) |-> !req_ready)
        else $error("ready while a descriptor is in flight");

    // No disable here: it must see reset itself
    a_reset_idle: assert property (@(posedge clock)
        rst |=> req_ready && !mem_rd && !mem_wr && !mem_lock && !notify_valid)
        else $error("outputs not idle after reset");
endmodule : pin_notify

// file: verification/pin_far_model.sv
// Purpose: Descriptor memory and notification sink
// Assumes: One locked transaction at a time
// Notes:   slow stretches every answer
`timescale 1ns/1ps
module pin_far_model (
    input  wire logic         clock,
    input  wire logic         slow,
    input  wire logic         mem_rd,
    input  wire logic         mem_wr,
    input  wire logic [63:0]  mem_addr,
    input  wire logic [511:0] mem_wdata,
    output logic              mem_rvalid,
    output logic [511:0]      mem_rdata,
    output logic              mem_wack,
    input  wire logic         notify_valid,
    output logic              notify_ready
);
    logic [511:0] mem [4];  // 64-byte slots
    int a;
    initial begin
        {mem_rvalid, mem_wack, mem_rdata} = '0;
        forever begin
            @(posedge clock);
            if (mem_rd) begin
                a = mem_addr[7:6];
                repeat (slow ? 3 : 0) @(posedge clock);
                mem_rvalid <= 1'b1;
                mem_rdata  <= mem[a];
                @(posedge clock);
                mem_rvalid <= 1'b0;
                mem_rdata  <= ~mem[a];  // Stale data never looks valid
                while (!mem_wr) @(posedge clock);
                repeat (slow ? 2 : 0) @(posedge clock);
                mem_wack <= 1'b1;
                mem[a]   <= mem_wdata;
                @(posedge clock);
                mem_wack <= 1'b0;
            end
        end
    end
    initial begin
        notify_ready = 1'b0;
        forever begin
            @(posedge clock);
            if (notify_valid) begin  // Taking it ends the pending state
                repeat (slow ? 4 : 0) @(posedge clock);
                notify_ready <= 1'b1;
                @(posedge clock);
                notify_ready <= 1'b0;
            end
        end
    end
endmodule : pin_far_model

// file: verification/testbench.sv
// Purpose: Self-checking bench for the posting block
// Assumes: Far-side model answers memory and notify
// Notes:   Every flag combination, both modes, both speeds
`timescale 1ns/1ps
module testbench;
    import pin_pkg::*;
    logic          clock = 0, rst = 1, req_valid = 0, slow = 0;
    pin_dst_mode_t dst_mode = PIN_DST_8;
    pin_remap_t    req = '0;
    logic [63:0]   req_addr = '0, mem_addr, exp_addr = '0;
    logic          req_ready, mem_rd, mem_wr, mem_lock, mem_rvalid, mem_wack, notify_valid, notify_ready;
    logic [511:0]  mem_wdata, mem_rdata;
    pin_notify_t   notify;
    pin_notify_t   seen_q[$];
    int            err_total = 0, total_checks = 0, cyc = 0;
    logic [31:0]   seed = 32'h7F62;
    always #4 clock = ~clock;
    pin_notify i_pin_notify (.clock(clock), .rst(rst), .dst_mode(dst_mode), .req_valid(req_valid),
        .req(req), .req_addr(req_addr), .req_ready(req_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_wack(mem_wack), .notify_valid(notify_valid), .notify(notify),
        .notify_ready(notify_ready));
    pin_far_model i_pin_far_model (.clock(clock), .slow(slow), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .mem_wack(mem_wack), .notify_valid(notify_valid), .notify_ready(notify_ready));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(string what, logic [511:0] seen, logic [511:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (mem_rd) chk("address", mem_addr, exp_addr);
        if (mem_rd || mem_wr) chk("lock held", 512'(mem_lock), 512'(1));
        if (notify_valid) chk("lock at notify", 512'(mem_lock), 512'(0));
        if (notify_valid && notify_ready) seen_q.push_back(notify);
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic post(int k, int t);
        logic [511:0] d;
        pin_remap_t   r;
        pin_notify_t  n;
        bit           snd;
        int           w;
        for (int i = 0; i < 10; i++) d[i*32+:32] = xs();
        d[511:320] = '0;  // Reserved kept zero
        d[287:280] = '0;
        d[271:258] = '0;
        d[257:256] = 2'(t);
        r = '{t[2], t[3], (k % 3 == 0) ? 8'h00 : (k % 3 == 1) ? 8'hFF : 8'(xs())};
        i_pin_far_model.mem[k % 4] = d;
        n = '{t[4] ? d[319:288] : {24'h0, d[303:296]}, d[279:272], 1'b1, 1'b1};
        d[r.vector] = 1'b1;
        snd = !(r.posting_mode_flag && !r.urgent_flag && d[257]) && !d[256];
        d[256] = d[256] | snd;
        exp_addr = 64'(k % 4) << 6;
        @(posedge clock);
        req_valid <= 1'b1;
        req       <= r;
        dst_mode  <= pin_dst_mode_t'(t[4]);
        req_addr  <= exp_addr | 64'(xs() & 32'h3F);
        @(posedge clock);
        req_valid <= 1'b0;
        @(posedge clock);
        w = 0;
        while (req_ready !== 1'b1 && w < 200) begin
            @(posedge clock);
            w++;
        end
        chk("ready in time", 512'(w < 200), 512'(1));
        chk("descriptor", i_pin_far_model.mem[k % 4], d);
        chk("notify count", 512'(seen_q.size()), 512'(snd));
        if (snd && seen_q.size() > 0) chk("notify", 512'(seen_q.pop_front()), 512'(n));
        seen_q.delete();
        $display("test %0d done", k);
    endtask : post
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 64; k++) begin
            if (k == 32) begin
                rst <= 1'b1;
                repeat (2) @(posedge clock);
                chk("reset lock", 512'({mem_lock, mem_wr}), 512'(0));
                chk("reset notify", 512'({req_ready, notify_valid}), 512'(2));
                rst <= 1'b0;
            end
            slow <= k[5];
            post(k, k % 32);
        end
        close_out();
    end
endmodule : testbench
